// >>> hw/pmc_pkg.sv
/*
  Constants, types and register map of the power mode and clock gating
  controller. Assumes a single system clock of 100 MHz and an 8-bit
  register port with a two-bit address.
*/
package pmc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [1:0] OFS_OSC = 2'h0;  // Oscillator control
   localparam logic [1:0] OFS_SEC = 2'h1;  // Secondary timer control
   localparam logic [1:0] OFS_STAT = 2'h2; // Controller state, read only

   // Field positions
   localparam int IDLE_BIT = 7;  // idle_on_sleep
   localparam int IFS_LSB = 4;   // internal_freq_select, three bits
   localparam int PRDY_BIT = 3;  // primary_clock_ready_flag
   localparam int SEL_LSB = 0;   // clock_source_select, two bits
   localparam int SACT_BIT = 6;  // secondary_clock_active_flag
   localparam int SEN_BIT = 3;   // secondary_osc_enable

   // Values after reset
   localparam logic [2:0] IFS_RST = 3'h3;
   localparam logic [1:0] SEL_RST = 2'h0;

   // Clock source codes
   localparam logic [1:0] SRC_PRI = 2'h0;
   localparam logic [1:0] SRC_SEC = 2'h1;
   localparam logic [1:0] SRC_INT = 2'h2;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 10;     // System clock period
   localparam int RDY_NS = 2000;  // CPU ready delay, plain default
   localparam int RDY_CYC = (RDY_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] RDY_CNT = CNT_W'(RDY_CYC);

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_IDLE = 5'h02,
      ST_SLEEP = 5'h04,
      ST_WAKE = 5'h08,
      ST_READY = 5'h10
   } pmState_e;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } regReq_s;

   typedef struct packed {
      logic pri;
      logic sec;
      logic hf;
   } oscRdy_s;

   typedef struct packed {
      logic pri;
      logic sec;
      logic hf;
      logic lf;
   } oscEn_s;

endpackage

// >>> hw/ready_delay.sv
/*
  CPU ready delay timer. A start pulse loads the count; done pulses for
  one cycle when it expires. Assumes start comes from logic on the same
  clock and is not repeated while the timer runs.
*/
module ready_delay (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic start,
   output logic done
);
   import pmc_pkg::*;

   logic busy_r, busy_nxt;            // Timer running
   logic [CNT_W-1:0] cnt_r, cnt_nxt;  // Cycles left
   logic done_r, done_nxt;            // Expiry pulse

   // ------------------------------------------------------------
   // Next count
   // ------------------------------------------------------------
   always_comb begin
      busy_nxt = busy_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      if (start) begin
         busy_nxt = 1'b1;
         cnt_nxt = RDY_CNT - CNT_W'(1);
      end else if (busy_r && cnt_r == '0) begin
         // Expired: pulse once and stop
         busy_nxt = 1'b0;
         done_nxt = 1'b1;
      end else if (busy_r) begin
         cnt_nxt = cnt_r - CNT_W'(1);
      end
   end

   // Registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         cnt_r <= '0;
         done_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;

endmodule

// >>> hw/power_mode_ctl.sv
/*
  Power mode controller: picks the system clock source, gates CPU and
  peripheral clocks for run, idle and sleep, and wakes on interrupt or
  watchdog time-out after a fixed CPU ready delay. Assumes oscillator
  ready levels arrive asynchronously and core events on this clock.
*/
// Notes on behaviour
// RULE_01: Select write switches source once it oscillates
// RULE_02: Sleep mode uses idle flag at command
// RULE_03: Sleep without idle stops all clocks
// RULE_04: Idle sleep keeps peripherals, gates CPU
// RULE_05: Select 00 is primary, reset default
// RULE_06: Select 01 runs secondary, primary off
// RULE_07: Secondary switch waits for enable and ready
// RULE_08: Select 1x runs internal block, primary off
// RULE_09: Internal frequency writable anytime, immediate effect
// RULE_10: Sleep stops oscillator, clears status flags
// RULE_11: Watchdog and enabled secondary oscillators keep running
// RULE_12: Sleep wake waits ready or uses internal
// RULE_13: Wake leaves idle flag and select unchanged
// RULE_14: Idle clocks peripherals, flags left alone
// RULE_15: Idle exits only on interrupt, watchdog, reset
// RULE_16: Wake waits ready delay, then matching run
// RULE_17: Watchdog time-out while asleep wakes, no reset
// RULE_18: Primary idle keeps primary clock and flag
// RULE_19: Software sets idle, clears select, then sleeps
// RULE_20: Enabled interrupt flag starts the wake exit
// RULE_21: Command registered, gates change next edge
module power_mode_ctl (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire pmc_pkg::regReq_s regReq,
   output logic [7:0] rdData,
   // Core events
   input wire logic sleepCmd,
   input wire logic wakeIrq,
   input wire logic wdtTimeout,
   // Configuration levels
   input wire logic twoSpeedEn,
   input wire logic failSafeEn,
   input wire logic wdtSelected,
   // Oscillator status, asynchronous
   input wire pmc_pkg::oscRdy_s oscReady,
   // Clock tree control
   output pmc_pkg::oscEn_s oscEnable,
   output logic cpuClkEn,
   output logic periClkEn,
   output logic [1:0] clkSel,
   output logic [2:0] intFreq
);
   import pmc_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   oscRdy_s sync1R, sync2R;           // Ready synchroniser stages
   pmState_e stateR, stateNxt;        // Power mode
   logic [1:0] selR, selNxt;          // clock_source_select
   logic [1:0] actR, actNxt;          // Source actually driving
   logic idleR, idleNxt;              // idle_on_sleep
   logic [2:0] ifsR, ifsNxt;          // internal_freq_select
   logic secEnR, secEnNxt;            // secondary_osc_enable
   logic sleepReqR, sleepReqNxt;      // Registered sleep command
   logic sleepIdleR, sleepIdleNxt;    // Idle flag caught with it
   logic priFlagR, priFlagNxt;        // primary_clock_ready_flag
   logic secActR, secActNxt;          // secondary_clock_active_flag
   oscEn_s oscEnR, oscEnNxt;          // Oscillator enables
   logic cpuClkEn_r, cpuNxt;          // CPU gate
   logic periClkEn_r, periNxt;        // Peripheral gate
   logic [7:0] rdData_r, rdNxt;       // Read data
   logic [1:0] want;                  // Source software asks for
   logic wake;                        // Any wake event
   logic asleep;                      // Sleep or wake next cycle
   logic delayStart;                  // Start ready delay
   logic delayDone;                   // Ready delay expired
   logic [CNT_W-1:0] readyCnt;        // Cycles spent in READY
   logic [2:0] wrIfs;                 // Frequency field of a write

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Source the select field resolves to; a secondary request with
   // the oscillator disabled keeps the present source
   function automatic logic [1:0] wantSrc(input logic [1:0] sel,
      input logic secEn, input logic [1:0] act);
      if (sel[1]) begin
         wantSrc = SRC_INT;
      end else if (sel[0]) begin
         wantSrc = secEn ? SRC_SEC : act;
      end else begin
         wantSrc = SRC_PRI;
      end
   endfunction

   // Whether a source is oscillating
   function automatic logic srcReady(input logic [1:0] src,
      input oscRdy_s rdy);
      if (src == SRC_PRI) begin
         srcReady = rdy.pri;
      end else if (src == SRC_SEC) begin
         srcReady = rdy.sec;
      end else begin
         srcReady = rdy.hf;
      end
   endfunction

   // ------------------------------------------------------------
   // Ready synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1R <= '0;
         sync2R <= '0;
      end else begin
         sync1R <= oscReady;
         sync2R <= sync1R;
      end
   end

   // ------------------------------------------------------------
   // Mode, source and register state
   // ------------------------------------------------------------
   assign wake = wakeIrq | wdtTimeout;  // [RULE_20] [RULE_17]
   assign wrIfs = regReq.wdata[IFS_LSB+:3];

   always_comb begin
      stateNxt = stateR;
      selNxt = selR;
      actNxt = actR;
      idleNxt = idleR;
      ifsNxt = ifsR;
      secEnNxt = secEnR;
      sleepReqNxt = 1'b0;
      sleepIdleNxt = sleepIdleR;
      delayStart = 1'b0;
      // Software writes; wake never touches these [RULE_13]
      if (regReq.wr && regReq.addr == OFS_OSC) begin
         idleNxt = regReq.wdata[IDLE_BIT];
         ifsNxt = wrIfs;  // Taken in any mode [RULE_09]
         selNxt = regReq.wdata[SEL_LSB+:2];
      end
      if (regReq.wr && regReq.addr == OFS_SEC) begin
         secEnNxt = regReq.wdata[SEN_BIT];
      end
      // Catch the idle flag with the command itself [RULE_02] [RULE_21]
      if (sleepCmd && stateR == ST_RUN && !sleepReqR) begin
         sleepReqNxt = 1'b1;
         sleepIdleNxt = idleR;
      end
      want = wantSrc(selR, secEnR, actR);
      unique case (stateR)
         ST_RUN: begin
            // Switch as soon as the target runs [RULE_01] [RULE_06] [RULE_07] [RULE_08]
            if (want != actR && srcReady(want, sync2R)) begin
               actNxt = want;
            end
            // No clock switch needed to go down [RULE_10]
            if (sleepReqR) begin
               stateNxt = sleepIdleR ? ST_IDLE : ST_SLEEP;  // [RULE_03] [RULE_04]
            end
         end
         ST_IDLE: begin
            // Peripherals follow the select field [RULE_14]
            if (want != actR && srcReady(want, sync2R)) begin
               actNxt = want;
            end
            // Only wake events restart the CPU [RULE_15]
            if (wake) begin
               stateNxt = ST_READY;
               delayStart = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (wake) begin
               stateNxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            // Clocks stay off until a source runs [RULE_12]
            if (srcReady(want, sync2R)) begin
               actNxt = want;
               stateNxt = ST_READY;
               delayStart = 1'b1;
            end else if ((twoSpeedEn || failSafeEn) && sync2R.hf) begin
               actNxt = SRC_INT;
               stateNxt = ST_READY;
               delayStart = 1'b1;
            end
         end
         ST_READY: begin
            // Run mode matches the source in use [RULE_16]
            if (delayDone) begin
               stateNxt = ST_RUN;
            end
         end
         default: begin
            stateNxt = ST_RUN;
         end
      endcase
      // Status flags are cleared by sleep, wake or a source change, not by idle [RULE_10] [RULE_14]
      asleep = (stateNxt == ST_SLEEP) || (stateNxt == ST_WAKE);
      priFlagNxt = !asleep && actNxt == SRC_PRI && sync2R.pri;  // [RULE_12] [RULE_18]
      secActNxt = !asleep && actNxt == SRC_SEC;  // [RULE_06]
      // Primary kept only while used or wanted [RULE_06] [RULE_08] [RULE_18]
      oscEnNxt.pri = stateNxt != ST_SLEEP && (actNxt == SRC_PRI || want == SRC_PRI);
      oscEnNxt.sec = secEnNxt;  // [RULE_11]
      oscEnNxt.hf = stateNxt != ST_SLEEP
         && (actNxt == SRC_INT || want == SRC_INT
         || (stateNxt == ST_WAKE && (twoSpeedEn || failSafeEn)));
      oscEnNxt.lf = wdtSelected || oscEnNxt.hf;  // [RULE_11]
      // Gates move on the edge that changes the mode [RULE_21]
      cpuNxt = stateNxt == ST_RUN;
      periNxt = stateNxt == ST_RUN || stateNxt == ST_IDLE || stateNxt == ST_READY;
   end

   // Registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stateR <= ST_RUN;
         selR <= SEL_RST;   // Primary after reset [RULE_05]
         actR <= SRC_PRI;   // [RULE_05]
         idleR <= 1'b0;
         ifsR <= IFS_RST;
         secEnR <= 1'b0;
         sleepReqR <= 1'b0;
         sleepIdleR <= 1'b0;
         priFlagR <= 1'b0;
         secActR <= 1'b0;
         oscEnR <= '0;
         cpuClkEn_r <= 1'b0;
         periClkEn_r <= 1'b0;
      end else begin
         stateR <= stateNxt;
         selR <= selNxt;
         actR <= actNxt;
         idleR <= idleNxt;
         ifsR <= ifsNxt;
         secEnR <= secEnNxt;
         sleepReqR <= sleepReqNxt;
         sleepIdleR <= sleepIdleNxt;
         priFlagR <= priFlagNxt;
         secActR <= secActNxt;
         oscEnR <= oscEnNxt;
         cpuClkEn_r <= cpuNxt;
         periClkEn_r <= periNxt;
      end
   end

   // CPU ready delay timer
   ready_delay u_delay (
      .clock(clock),
      .rst_n(rst_n),
      .start(delayStart),
      .done(delayDone)
   );

   // ------------------------------------------------------------
   // Read back
   // ------------------------------------------------------------
   // Unmapped offsets answer zero
   always_comb begin
      rdNxt = 8'h00;
      if (regReq.rd) begin
         unique case (regReq.addr)
            OFS_OSC: begin
               rdNxt[IDLE_BIT] = idleR;
               rdNxt[IFS_LSB+:3] = ifsR;
               rdNxt[PRDY_BIT] = priFlagR;
               rdNxt[SEL_LSB+:2] = selR;
            end
            OFS_SEC: begin
               rdNxt[SACT_BIT] = secActR;
               rdNxt[SEN_BIT] = secEnR;
            end
            OFS_STAT: begin
               rdNxt = {3'h0, stateR};
            end
            default: begin
               rdNxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= rdNxt;
      end
   end

   // Outputs, all from flip-flops
   assign rdData = rdData_r;
   assign oscEnable = oscEnR;
   assign cpuClkEn = cpuClkEn_r;
   assign periClkEn = periClkEn_r;
   assign clkSel = actR;
   assign intFreq = ifsR;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Cycle count inside READY, read only by the checks
   always_ff @(posedge clock) begin
      if (!rst_n || stateR != ST_READY) begin
         readyCnt <= '0;
      end else begin
         readyCnt <= readyCnt + CNT_W'(1);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_cmd(logic idl);
      sleepCmd && stateR == ST_RUN && !sleepReqR && idleR == idl;
   endsequence
   sequence s_gated;
      !cpuClkEn_r && !periClkEn_r;
   endsequence

   property p_sleepEntry;
      s_cmd(1'b0) |=> ##1 s_gated;
   endproperty
   a_sleepEntry: assert property (p_sleepEntry) else $error("sleep gating late"); // [RULE_03]
   property p_idleEntry;
      s_cmd(1'b1) |=> ##1 (periClkEn_r && !cpuClkEn_r);
   endproperty
   a_idleEntry: assert property (p_idleEntry) else $error("idle gating wrong"); // [RULE_04]
   property p_sleepFlags;
      stateR == ST_SLEEP |-> !priFlagR && !secActR && !oscEnR.pri;
   endproperty
   a_sleepFlags: assert property (p_sleepFlags) else $error("flags kept in sleep"); // [RULE_10]
   property p_idleHold;
      stateR == ST_IDLE && !wake |=> stateR == ST_IDLE;
   endproperty
   a_idleHold: assert property (p_idleHold) else $error("idle left without wake"); // [RULE_15]
   property p_delayHold;
      stateR == ST_READY && readyCnt < RDY_CNT |=> stateR == ST_READY && !cpuClkEn_r;
   endproperty
   a_delayHold: assert property (p_delayHold) else $error("cpu resumed early"); // [RULE_16]
   property p_delayEnd;
      stateR == ST_READY && readyCnt == RDY_CNT |=> stateR == ST_RUN && cpuClkEn_r;
   endproperty
   a_delayEnd: assert property (p_delayEnd) else $error("cpu resumed late"); // [RULE_16]
   property p_secSwitch;
      stateR == ST_RUN && !sleepReqR && selR == SRC_SEC && secEnR && sync2R.sec
         && actR != SRC_SEC |=> actR == SRC_SEC && secActR && !priFlagR && !oscEnR.pri;
   endproperty
   a_secSwitch: assert property (p_secSwitch) else $error("secondary switch wrong"); // [RULE_06]
   property p_secHold;
      stateR == ST_RUN && selR == SRC_SEC && !secEnR && actR != SRC_SEC |=> actR != SRC_SEC;
   endproperty
   a_secHold: assert property (p_secHold) else $error("secondary taken disabled"); // [RULE_07]
   property p_intSwitch;
      stateR == ST_RUN && !sleepReqR && selR[1] && sync2R.hf |=> actR == SRC_INT && !priFlagR;
   endproperty
   a_intSwitch: assert property (p_intSwitch) else $error("internal switch wrong"); // [RULE_08]
   property p_wakeKeep;
      (stateR == ST_IDLE || stateR == ST_SLEEP) && wake && !regReq.wr
         |=> $stable(selR) && $stable(idleR);
   endproperty
   a_wakeKeep: assert property (p_wakeKeep) else $error("wake altered control"); // [RULE_13]
   property p_freq;
      regReq.wr && regReq.addr == OFS_OSC |=> intFreq == $past(wrIfs);
   endproperty
   a_freq: assert property (p_freq) else $error("frequency write lost"); // [RULE_09]
   property p_lfRun;
      stateR == ST_SLEEP && $past(wdtSelected) |-> oscEnR.lf;
   endproperty
   a_lfRun: assert property (p_lfRun) else $error("watchdog oscillator off"); // [RULE_11]
   property p_priIdle;
      stateR == ST_IDLE && actR == SRC_PRI && selR == SRC_PRI && sync2R.pri
         |=> priFlagR && oscEnR.pri;
   endproperty
   a_priIdle: assert property (p_priIdle) else $error("primary idle lost clock"); // [RULE_18]

endmodule

// >>> dv/cpu_core_model.sv
/*
  Behavioural CPU core for the power mode controller: issues register
  writes, reads and sleep commands when the bench asks. Assumes it runs
  on the controller's own clock and that the bench never overlaps calls.
*/
module cpu_core_model (
   // Clock
   input wire logic clock,
   // Requests towards the controller
   output pmc_pkg::regReq_s regReq,
   output logic sleepCmd,
   // Answer from the controller
   input wire logic [7:0] rdData
);
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;

   // ---------------------------------------------
   // Bus and command drivers
   // ---------------------------------------------
   // Quiet bus from time zero, so nothing is taken during reset
   initial begin
      regReq = '0;
      sleepCmd = 1'b0;
   end

   // One write cycle; strobe held up to the edge that takes it
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      regReq.wr <= 1'b0;
   endtask

   // One read cycle; data stand only in the following cycle
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock);
      regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      regReq.rd <= 1'b0;
      @(negedge clock);
      d = rdData;
   endtask

   // Sleep command pulse; callers set the idle flag and select first
   task automatic sleep();
      @(posedge clock);
      sleepCmd <= 1'b1;
      @(posedge clock);
      sleepCmd <= 1'b0;
   endtask
endmodule

// >>> dv/power_mode_clock_gating_controller_bench.sv
/*
  Self-checking bench of the power mode controller: a table of source
  selections, then idle, sleep, two-speed wake and reset cases. Assumes
  oscillators that become ready a fixed number of cycles after enable.
*/
module power_mode_clock_gating_controller_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;

   // ---------------------------------------------
   // Signals and oscillator start-up figures
   // ---------------------------------------------
   localparam int PRI_DLY = 40; // Primary warms up slowly
   localparam int SEC_DLY = 6;
   localparam int HF_DLY = 4;
   logic clock, rst_n, wakeIrq, wdtTimeout, twoSpeedEn, failSafeEn, wdtSelected, sleepCmd;
   regReq_s regReq;
   logic [7:0] rdData, rv;
   oscRdy_s oscReady;
   oscEn_s oscEnable;
   logic cpuClkEn, periClkEn;
   logic [1:0] clkSel;
   logic [2:0] intFreq;
   int error_cnt = 0;
   int check_count = 0;
   int priCnt = 0, secCnt = 0, hfCnt = 0, n;
   typedef struct {
      logic [7:0] sec, osc, oscRd, secRd;
      logic [1:0] sel;
      logic priEn;
   } row_s;
   row_s rows[5] = '{
      '{8'h00, 8'h01, 8'h09, 8'h00, 2'h0, 1'b1},
      '{8'h08, 8'h51, 8'h51, 8'h48, 2'h1, 1'b0},
      '{8'h08, 8'h72, 8'h72, 8'h08, 2'h2, 1'b0},
      '{8'h08, 8'h23, 8'h23, 8'h08, 2'h2, 1'b0},
      '{8'h00, 8'h30, 8'h38, 8'h00, 2'h0, 1'b1}};

   // ---------------------------------------------
   // Design, core model and oscillators
   // ---------------------------------------------
   power_mode_ctl DUT (.clock(clock), .rst_n(rst_n), .regReq(regReq), .rdData(rdData),
      .sleepCmd(sleepCmd), .wakeIrq(wakeIrq), .wdtTimeout(wdtTimeout),
      .twoSpeedEn(twoSpeedEn), .failSafeEn(failSafeEn), .wdtSelected(wdtSelected),
      .oscReady(oscReady), .oscEnable(oscEnable), .cpuClkEn(cpuClkEn),
      .periClkEn(periClkEn), .clkSel(clkSel), .intFreq(intFreq));
   cpu_core_model core (.clock(clock), .regReq(regReq), .sleepCmd(sleepCmd), .rdData(rdData));

   // Ready only after a run of enabled cycles; drops at once when disabled
   always_ff @(posedge clock) begin
      priCnt <= (oscEnable.pri === 1'b1) ? ((priCnt < PRI_DLY) ? priCnt + 1 : priCnt) : 0;
      secCnt <= (oscEnable.sec === 1'b1) ? ((secCnt < SEC_DLY) ? secCnt + 1 : secCnt) : 0;
      hfCnt <= (oscEnable.hf === 1'b1) ? ((hfCnt < HF_DLY) ? hfCnt + 1 : hfCnt) : 0;
   end
   assign oscReady = {priCnt == PRI_DLY, secCnt == SEC_DLY, hfCnt == HF_DLY};

   // Clock of 10 ns
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ---------------------------------------------
   // Compare, wake and closing tasks
   // ---------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_range(input int got, input int lo, input int hi, input string what);
      check_count++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("mismatch at %0t: %s took %0d cycles", $time, what, got);
      end
   endtask

   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string what);
      core.rd(a, rv);
      check(rv, exp, what);
   endtask

   // One-cycle wake pulse, from the watchdog or an interrupt
   task automatic wake(input bit useWdt);
      @(posedge clock);
      if (useWdt) begin
         wdtTimeout <= 1'b1;
      end else begin
         wakeIrq <= 1'b1;
      end
      @(posedge clock);
      wdtTimeout <= 1'b0;
      wakeIrq <= 1'b0;
   endtask

   // Cycles until the CPU clock returns, bounded so a hang cannot stall
   task automatic wait_cpu(output int cnt);
      cnt = 0;
      while (cpuClkEn !== 1'b1 && cnt < 1000) begin
         @(negedge clock);
         cnt++;
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog: the whole run needs under two thousand cycles
   initial begin
      #200000;
      error_cnt++;
      close_out();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      rst_n = 1'b0;
      {wakeIrq, wdtTimeout, twoSpeedEn, failSafeEn} = '0;
      wdtSelected = 1'b1;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      check({6'h00, clkSel}, {6'h00, SRC_PRI}, "reset source");
      check({5'h00, intFreq}, {5'h00, IFS_RST}, "reset freq");
      rd_chk(2'h3, 8'h00, "unmapped read");
      // Table of selections; oscillators follow their enables
      foreach (rows[i]) begin
         core.wr(OFS_SEC, rows[i].sec);
         core.wr(OFS_OSC, rows[i].osc);
         @(negedge clock);
         check({5'h00, intFreq}, {5'h00, rows[i].osc[6:4]}, "freq");
         repeat (60) @(posedge clock);
         @(negedge clock);
         check({6'h00, clkSel}, {6'h00, rows[i].sel}, "source");
         check({7'h00, oscEnable.pri}, {7'h00, rows[i].priEn}, "pri on");
         rd_chk(OFS_OSC, rows[i].oscRd, "osc reg");
         rd_chk(OFS_SEC, rows[i].secRd, "sec reg");
      end
      $display("test selection table done");
      // Primary idle; idle flag cleared right after the command
      core.wr(OFS_OSC, 8'hB0);
      core.sleep();
      core.wr(OFS_OSC, 8'h30);
      @(negedge clock);
      check({6'h00, cpuClkEn, periClkEn}, 8'h01, "idle gates");
      check({7'h00, oscEnable.pri}, 8'h01, "idle pri");
      core.sleep();
      repeat (20) @(posedge clock);
      @(negedge clock);
      check({7'h00, cpuClkEn}, 8'h00, "idle no exit");
      rd_chk(OFS_OSC, 8'h38, "idle flags");
      rd_chk(OFS_STAT, {3'h0, ST_IDLE}, "idle state");
      wake(1'b1);
      wait_cpu(n);
      check_range(n, RDY_CYC, RDY_CYC + 3, "idle wake");
      check({6'h00, clkSel}, 8'h00, "after idle");
      rd_chk(OFS_OSC, 8'h38, "after idle regs");
      $display("test idle done");
      // Full sleep with watchdog and secondary oscillators kept alive
      core.wr(OFS_SEC, 8'h08);
      core.sleep();
      repeat (3) @(posedge clock);
      @(negedge clock);
      check({6'h00, cpuClkEn, periClkEn}, 8'h00, "sleep gates");
      check({4'h0, oscEnable.pri, oscEnable.sec, oscEnable.lf, oscEnable.hf}, 8'h06, "sleep osc");
      rd_chk(OFS_OSC, 8'h30, "sleep flags");
      wake(1'b0);
      repeat (20) @(posedge clock);
      @(negedge clock);
      check({6'h00, cpuClkEn, periClkEn}, 8'h00, "wake waits");
      wait_cpu(n);
      check_range(n, RDY_CYC, 999, "sleep wake");
      rd_chk(OFS_OSC, 8'h38, "after sleep");
      $display("test sleep done");
      // Two-speed, then fail-safe: wake runs from the internal block meanwhile
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         twoSpeedEn <= (k == 0);
         failSafeEn <= (k == 1);
         core.sleep();
         repeat (5) @(posedge clock);
         wake(1'b0);
         repeat (15) @(posedge clock);
         @(negedge clock);
         check({5'h00, periClkEn, clkSel}, 8'h06, "two-speed");
         wait_cpu(n);
         repeat (5) @(posedge clock);
         @(negedge clock);
         check({6'h00, clkSel}, 8'h00, "back to primary");
      end
      @(posedge clock);
      twoSpeedEn <= 1'b0;
      failSafeEn <= 1'b0;
      $display("test two-speed done");
      // Reset in mid-run returns to primary defaults
      core.wr(OFS_OSC, 8'h02);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (60) @(posedge clock);
      @(negedge clock);
      check({3'h0, intFreq, clkSel}, {3'h0, IFS_RST, SRC_PRI}, "second reset");
      rd_chk(OFS_OSC, 8'h38, "reset regs");
      $display("test reset done");
      close_out();
   end
endmodule
